// ### src/mmaip_input_port.sv
/*
  Input port of a micromirror array: double-data-rate pixel link capture,
  stepped address and mirror reset serial control, reset driver gating.
  Assumes the controller drives link pins source-synchronously and holds
  the serial lines still while it pulses the reset latch strobe.
*/
// What this block does
// (R1) Capture all fifteen data bits on both edges of the parallel clock.
// (R2) Parallel clock alone times the data and control pins of that link.
// (R3) Row latch load sampled on both parallel clock edges.
// (R4) Serial sync control sampled on both parallel clock edges.
// (R5) Toggle rate control sampled on both parallel clock edges.
// (R6) Stepped address link runs on its own separate clock.
// (R7) Stepped address line sampled only on rising stepped address clock edges.
// (R8) Mirror reset line sampled on rising stepped address clock edges.
// (R9) Strobe rising edge latches shifted control; latched values hold between strobes.
// (R10) Mirror reset drivers enabled only while the enable input is low.
// (R11) Controller keeps drivers disabled until valid control has been latched.
`timescale 1ns/10ps
`default_nettype none
module mmaip_input_port
  import mmaip_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              parallel_ddr_clock,
  input  wire logic [DATA_W-1:0] pixel_data_in,
  input  wire logic              row_latch_load,
  input  wire logic              serial_sync_control,
  input  wire logic              toggle_rate_control,
  input  wire logic              stepped_address_clock,
  input  wire logic              stepped_address_serial_line,
  input  wire logic              mirror_reset_serial_line,
  input  wire logic              reset_latch_strobe,
  input  wire logic              reset_driver_output_enable_n,
  input  wire logic              pixel_ready,
  input  wire logic              overflow_clear,
  output wire logic              pixel_valid,
  output wire logic [DATA_W-1:0] pixel_data_rise,
  output wire logic [DATA_W-1:0] pixel_data_fall,
  output wire logic              row_latch_load_rise,
  output wire logic              row_latch_load_fall,
  output wire logic              serial_sync_rise,
  output wire logic              serial_sync_fall,
  output wire logic              toggle_rate_rise,
  output wire logic              toggle_rate_fall,
  output wire logic              pixel_overflow,
  output wire logic [SHIFT_W-1:0] stepped_address_word,
  output wire logic [SHIFT_W-1:0] mirror_reset_word,
  output wire logic              reset_drivers_enable,
  output wire logic [SHIFT_W-1:0] reset_driver_out
);
  // ----------------------------------------------------------------
  // Parallel link domain
  // ----------------------------------------------------------------
  logic                lrst_s1_ff, lrst_ff;
  logic [SAMPLE_W-1:0] rise_smp_ff, fall_smp_ff;
  logic                primed_ff, ovf_tog_ff;
  logic                wr_ready;
  logic [WORD_W-1:0]   wr_word;
  logic [SAMPLE_W-1:0] pin_smp;

  assign pin_smp = {toggle_rate_control, serial_sync_control, row_latch_load, pixel_data_in};
  assign wr_word = {rise_smp_ff, fall_smp_ff};

  // Reset releases on the link clock so the first captured edge is clean
  // The link clock must run across release, or capture stays held in reset
  always_ff @(posedge parallel_ddr_clock or posedge rst) begin
    if (rst) begin
      lrst_s1_ff <= 1'b1;
      lrst_ff    <= 1'b1;
    end else begin
      lrst_s1_ff <= 1'b0;
      lrst_ff    <= lrst_s1_ff;
    end
  end

  // Rising half of each pair, then the pair is pushed on the next rising edge
  always_ff @(posedge parallel_ddr_clock or posedge lrst_ff) begin
    if (lrst_ff) begin
      rise_smp_ff <= '0;
      primed_ff   <= 1'b0;
      ovf_tog_ff  <= 1'b0;
    end else begin
      rise_smp_ff <= pin_smp; // R1 R2 R3 R4 R5
      primed_ff   <= 1'b1;
      // The pins cannot be stalled, so a full FIFO drops the pair and says so
      if (primed_ff && !wr_ready) begin
        ovf_tog_ff <= ~ovf_tog_ff;
      end
    end
  end

  // Falling half completes the pair before the next rising edge pushes it
  always_ff @(negedge parallel_ddr_clock or posedge lrst_ff) begin
    if (lrst_ff) begin
      fall_smp_ff <= '0;
    end else begin
      fall_smp_ff <= pin_smp; // R1 R2 R3 R4 R5
    end
  end

  // ----------------------------------------------------------------
  // Stepped address domain
  // ----------------------------------------------------------------
  logic               srst_s1_ff, srst_ff;
  logic [SHIFT_W-1:0] sa_shift_ff, mr_shift_ff;

  // Serial shifting starts on the third stepped address clock edge after release
  always_ff @(posedge stepped_address_clock or posedge rst) begin
    if (rst) begin
      srst_s1_ff <= 1'b1;
      srst_ff    <= 1'b1;
    end else begin
      srst_s1_ff <= 1'b0;
      srst_ff    <= srst_s1_ff;
    end
  end

  always_ff @(posedge stepped_address_clock or posedge srst_ff) begin // R6
    if (srst_ff) begin
      sa_shift_ff <= SHIFT_RST;
      mr_shift_ff <= SHIFT_RST;
    end else begin
      sa_shift_ff <= {sa_shift_ff[SHIFT_W-2:0], stepped_address_serial_line}; // R7
      mr_shift_ff <= {mr_shift_ff[SHIFT_W-2:0], mirror_reset_serial_line}; // R8
    end
  end

  // ----------------------------------------------------------------
  // Core domain
  // ----------------------------------------------------------------
  // Toggle and strobe take three stages: two to synchronise, one to find the edge
  typedef struct packed {
    logic               pix_valid;
    logic [WORD_W-1:0]  pix_word;
    logic               ovf_s1;
    logic               ovf_s2;
    logic               ovf_s3;
    logic               overflow;
    logic               strb_s1;
    logic               strb_s2;
    logic               strb_s3;
    logic               oen_s1;
    logic               oen_s2;
    logic [SHIFT_W-1:0] sa_s1;
    logic [SHIFT_W-1:0] sa_s2;
    logic [SHIFT_W-1:0] mr_s1;
    logic [SHIFT_W-1:0] mr_s2;
    logic [SHIFT_W-1:0] sa_latched;
    logic [SHIFT_W-1:0] mr_latched;
    logic               drv_en;
    logic [SHIFT_W-1:0] drv_out;
  } mmaip_core_s;

  mmaip_core_s state_ff, nxt_state;
  logic              rd_valid, rd_ready;
  logic [WORD_W-1:0] rd_word;
  logic              strobe_edge, ovf_pulse;

  // Pairs reach the core clock through gray pointers, never bitwise
  mmaip_async_fifo #(
    .W     (WORD_W),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .wr_clk   (parallel_ddr_clock),
    .wr_rst   (lrst_ff),
    .wr_valid (primed_ff),
    .wr_ready (wr_ready),
    .wr_data  (wr_word),
    .rd_clk   (clock),
    .rd_rst   (rst),
    .rd_valid (rd_valid),
    .rd_ready (rd_ready),
    .rd_data  (rd_word)
  );

  // Output stage refills in the same cycle the consumer takes a word
  assign rd_ready    = !state_ff.pix_valid || pixel_ready;
  assign strobe_edge = state_ff.strb_s2 && !state_ff.strb_s3;
  assign ovf_pulse   = state_ff.ovf_s2 ^ state_ff.ovf_s3;

  always_comb begin
    nxt_state = state_ff;
    if (rd_ready) begin
      nxt_state.pix_valid = rd_valid;
      if (rd_valid) begin
        nxt_state.pix_word = rd_word;
      end
    end
    nxt_state.ovf_s1 = ovf_tog_ff;
    nxt_state.ovf_s2 = state_ff.ovf_s1;
    nxt_state.ovf_s3 = state_ff.ovf_s2;
    // A drop in the same cycle as the clear keeps the flag set
    if (ovf_pulse) begin
      nxt_state.overflow = 1'b1;
    end else if (overflow_clear) begin
      nxt_state.overflow = 1'b0;
    end
    // Strobe and enable pins are asynchronous, so two flops come first
    nxt_state.strb_s1 = reset_latch_strobe;
    nxt_state.strb_s2 = state_ff.strb_s1;
    nxt_state.strb_s3 = state_ff.strb_s2;
    nxt_state.oen_s1  = reset_driver_output_enable_n;
    nxt_state.oen_s2  = state_ff.oen_s1;
    // Shift registers are quiet around a strobe, so bitwise sync is coherent
    nxt_state.sa_s1   = sa_shift_ff;
    nxt_state.sa_s2   = state_ff.sa_s1;
    nxt_state.mr_s1   = mr_shift_ff;
    nxt_state.mr_s2   = state_ff.mr_s1;
    if (strobe_edge) begin
      nxt_state.sa_latched = state_ff.sa_s2; // R9
      nxt_state.mr_latched = state_ff.mr_s2; // R9
    end
    nxt_state.drv_en  = !state_ff.oen_s2; // R10
    // Drivers idle at all zero, so a stale word never reaches them
    nxt_state.drv_out = state_ff.oen_s2 ? SHIFT_RST : state_ff.mr_latched; // R10 R11
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_ff <= '{oen_s1: 1'b1, oen_s2: 1'b1, pix_word: WORD_RST, default: '0};
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Every output is a plain copy of a core flip-flop
  assign pixel_valid          = state_ff.pix_valid;
  assign pixel_data_rise      = state_ff.pix_word[WORD_RISE_LSB+SMP_DATA_LSB +: DATA_W];
  assign pixel_data_fall      = state_ff.pix_word[WORD_FALL_LSB+SMP_DATA_LSB +: DATA_W];
  assign row_latch_load_rise  = state_ff.pix_word[WORD_RISE_LSB+SMP_LOAD_BIT];
  assign row_latch_load_fall  = state_ff.pix_word[WORD_FALL_LSB+SMP_LOAD_BIT];
  assign serial_sync_rise     = state_ff.pix_word[WORD_RISE_LSB+SMP_SYNC_BIT];
  assign serial_sync_fall     = state_ff.pix_word[WORD_FALL_LSB+SMP_SYNC_BIT];
  assign toggle_rate_rise     = state_ff.pix_word[WORD_RISE_LSB+SMP_TRC_BIT];
  assign toggle_rate_fall     = state_ff.pix_word[WORD_FALL_LSB+SMP_TRC_BIT];
  assign pixel_overflow       = state_ff.overflow;
  assign stepped_address_word = state_ff.sa_latched;
  assign mirror_reset_word    = state_ff.mr_latched;
  assign reset_drivers_enable = state_ff.drv_en;
  assign reset_driver_out     = state_ff.drv_out;

  // ----------------------------------------------------------------
  // Assertions: parallel link capture
  // ----------------------------------------------------------------
  a_rise_half_pair: assert property (@(posedge parallel_ddr_clock) disable iff (lrst_ff) // R1
    primed_ff |-> wr_word[WORD_RISE_LSB +: SAMPLE_W] == $past(pin_smp))
    else $error("Rising half does not match pins at previous rising edge");
  a_fall_half_pair: assert property (@(negedge parallel_ddr_clock) disable iff (lrst_ff) // R1 R2
    ##1 fall_smp_ff == $past(pin_smp))
    else $error("Falling half does not match pins at previous falling edge");

  // ----------------------------------------------------------------
  // Assertions: core output stage
  // ----------------------------------------------------------------
  a_stall_holds_word: assert property (@(posedge clock) disable iff (rst)
    pixel_valid && !pixel_ready |=> pixel_valid && $stable(state_ff.pix_word))
    else $error("Pixel word changed while stalled");
  a_fifo_to_output: assert property (@(posedge clock) disable iff (rst)
    rd_valid && rd_ready |=> pixel_valid && state_ff.pix_word == $past(rd_word))
    else $error("FIFO word not presented next cycle");
  a_drop_flags_overflow: assert property (@(posedge clock) disable iff (rst)
    ovf_pulse |=> pixel_overflow)
    else $error("Dropped pair did not raise overflow");

  // ----------------------------------------------------------------
  // Assertions: serial control and drivers
  // ----------------------------------------------------------------
  a_address_shift: assert property (@(posedge stepped_address_clock) // R6 R7
    disable iff (srst_ff)
    ##1 sa_shift_ff == {$past(sa_shift_ff[SHIFT_W-2:0]), $past(stepped_address_serial_line)})
    else $error("Stepped address shift wrong");
  a_reset_line_shift: assert property (@(posedge stepped_address_clock) // R8
    disable iff (srst_ff)
    ##1 mr_shift_ff == {$past(mr_shift_ff[SHIFT_W-2:0]), $past(mirror_reset_serial_line)})
    else $error("Mirror reset line not shifted in");
  a_strobe_latches: assert property (@(posedge clock) disable iff (rst) // R9
    $rose(state_ff.strb_s2) |=> mirror_reset_word == $past(state_ff.mr_s2))
    else $error("Strobe did not latch reset control");
  a_address_latches: assert property (@(posedge clock) disable iff (rst) // R9
    strobe_edge |=> stepped_address_word == $past(state_ff.sa_s2))
    else $error("Strobe did not latch stepped address");
  a_latch_holds: assert property (@(posedge clock) disable iff (rst) // R9
    !strobe_edge |=> $stable(mirror_reset_word) && $stable(stepped_address_word))
    else $error("Latched control changed without strobe");
  a_drivers_off_high: assert property (@(posedge clock) disable iff (rst) // R10
    state_ff.oen_s2 |=> !reset_drivers_enable && reset_driver_out == SHIFT_RST)
    else $error("Drivers active while enable input high");
  a_drivers_on_low: assert property (@(posedge clock) disable iff (rst) // R10
    !state_ff.oen_s2 |=> reset_drivers_enable && reset_driver_out == $past(mirror_reset_word))
    else $error("Drivers not following latched word while enable input low");

  // ----------------------------------------------------------------
  // Cover properties
  // ----------------------------------------------------------------
  c_pixel_taken: cover property (@(posedge clock) disable iff (rst) pixel_valid && pixel_ready);
  c_pixel_stall: cover property (@(posedge clock) disable iff (rst) pixel_valid && !pixel_ready);
  c_overflow: cover property (@(posedge clock) disable iff (rst) $rose(pixel_overflow));
  c_strobe: cover property (@(posedge clock) disable iff (rst) strobe_edge);
  c_drivers_on: cover property (@(posedge clock) disable iff (rst) $rose(reset_drivers_enable));
endmodule // mmaip_input_port
`default_nettype wire

// ### src/mmaip_pkg.sv
/*
  Constants shared by the micromirror array input port and its FIFO.
  Assumes nothing of its surroundings beyond a SystemVerilog compiler.
*/
`default_nettype none
package mmaip_pkg;
  // ----------------------------------------------------------------
  // Parallel double-data-rate link
  // ----------------------------------------------------------------
  localparam int DATA_W          = 15;
  localparam int SAMPLE_W        = 18;  // Data, row load, sync, toggle rate
  localparam int SMP_DATA_LSB    = 0;
  localparam int SMP_LOAD_BIT    = 15;
  localparam int SMP_SYNC_BIT    = 16;
  localparam int SMP_TRC_BIT     = 17;
  localparam int WORD_W          = 36;  // Rising half above falling half
  localparam int WORD_FALL_LSB   = 0;
  localparam int WORD_RISE_LSB   = 18;
  // ----------------------------------------------------------------
  // Buffering
  // ----------------------------------------------------------------
  localparam int FIFO_DEPTH      = 16;
  localparam int FIFO_AW         = 4;
  // ----------------------------------------------------------------
  // Stepped address and mirror reset serial control
  // ----------------------------------------------------------------
  localparam int SHIFT_W         = 16;
  localparam logic [15:0] SHIFT_RST = 16'h0000;
  localparam logic [35:0] WORD_RST  = 36'h0_0000_0000;
endpackage : mmaip_pkg
`default_nettype wire

// ### src/mmaip_async_fifo.sv
/*
  Dual-clock FIFO with gray-coded pointers crossing between domains.
  Assumes each reset is asserted asynchronously and released in its own domain.
*/
`timescale 1ns/10ps
`default_nettype none
module mmaip_async_fifo #(
  parameter int W     = 36,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  input  wire logic         wr_clk,
  input  wire logic         wr_rst,
  input  wire logic         wr_valid,
  output wire logic         wr_ready,
  input  wire logic [W-1:0] wr_data,
  input  wire logic         rd_clk,
  input  wire logic         rd_rst,
  output wire logic         rd_valid,
  input  wire logic         rd_ready,
  output wire logic [W-1:0] rd_data
);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wbin_ff, wgray_ff, rgs1_ff, rgs2_ff;
  logic [AW:0]  rbin_ff, rgray_ff, wgs1_ff, wgs2_ff;
  logic [AW:0]  wbin_inc, rbin_inc;

  function automatic logic [AW:0] to_gray(input logic [AW:0] b);
    to_gray = b ^ (b >> 1);
  endfunction

  // ----------------------------------------------------------------
  // Write side
  // ----------------------------------------------------------------
  assign wbin_inc = wbin_ff + {{AW{1'b0}}, 1'b1};
  // Full when the write pointer is one lap ahead of the synced read pointer
  assign wr_ready = (wgray_ff != {~rgs2_ff[AW:AW-1], rgs2_ff[AW-2:0]});

  always_ff @(posedge wr_clk) begin
    if (wr_valid && wr_ready) begin
      mem[wbin_ff[AW-1:0]] <= wr_data;
    end
  end

  always_ff @(posedge wr_clk or posedge wr_rst) begin
    if (wr_rst) begin
      wbin_ff  <= '0;
      wgray_ff <= '0;
      rgs1_ff  <= '0;
      rgs2_ff  <= '0;
    end else begin
      rgs1_ff <= rgray_ff;
      rgs2_ff <= rgs1_ff;
      if (wr_valid && wr_ready) begin
        wbin_ff  <= wbin_inc;
        wgray_ff <= to_gray(wbin_inc);
      end
    end
  end

  // ----------------------------------------------------------------
  // Read side
  // ----------------------------------------------------------------
  assign rbin_inc = rbin_ff + {{AW{1'b0}}, 1'b1};
  assign rd_valid = (rgray_ff != wgs2_ff);
  assign rd_data  = mem[rbin_ff[AW-1:0]];

  always_ff @(posedge rd_clk or posedge rd_rst) begin
    if (rd_rst) begin
      rbin_ff  <= '0;
      rgray_ff <= '0;
      wgs1_ff  <= '0;
      wgs2_ff  <= '0;
    end else begin
      wgs1_ff <= wgray_ff;
      wgs2_ff <= wgs1_ff;
      if (rd_valid && rd_ready) begin
        rbin_ff  <= rbin_inc;
        rgray_ff <= to_gray(rbin_inc);
      end
    end
  end
endmodule // mmaip_async_fifo
`default_nettype wire

// ### test/mmaip_ctrl_model.sv
/*
  Behavioural display controller that drives both links of the input port.
  Assumes the bench calls send and shift_words and reads exp_q and pend.
*/
`timescale 1ns/10ps
`default_nettype none
module mmaip_ctrl_model
  import mmaip_pkg::*;
(
  output var logic              parallel_ddr_clock,
  output var logic [DATA_W-1:0] pixel_data_in,
  output var logic              row_latch_load,
  output var logic              serial_sync_control,
  output var logic              toggle_rate_control,
  output var logic              stepped_address_clock,
  output var logic              stepped_address_serial_line,
  output var logic              mirror_reset_serial_line
);
  logic [WORD_W-1:0]   exp_q[$];
  int                  pend;
  logic [13:0]         seq;
  logic [SAMPLE_W-1:0] pins;
  logic [SAMPLE_W-1:0] r_smp;

  assign {toggle_rate_control, serial_sync_control, row_latch_load, pixel_data_in} = pins;

  task automatic send(input int n);
    pend = pend + n;
  endtask

  // ----------------------------------------------------------------
  // Parallel link: clock runs free, idle pairs are all zero
  // ----------------------------------------------------------------
  initial begin
    parallel_ddr_clock = 1'b0;
    pend = 0;
    seq = '0;
    pins = '0;
    #7;
    forever begin
      r_smp = '0;
      if (pend > 0) begin
        r_smp = {seq[2:0], 1'b1, seq};
        pend = pend - 1;
        seq = seq + 14'h1;
        exp_q.push_back({r_smp, ~r_smp});
      end
      // Pins move midway between edges; falling half is the inverse
      pins = r_smp;
      #20 parallel_ddr_clock = 1'b1;
      #20 pins = (r_smp == '0) ? '0 : ~r_smp;
      #20 parallel_ddr_clock = 1'b0;
      #20;
    end
  end

  // ----------------------------------------------------------------
  // Serial link: clock stands still outside frames
  // ----------------------------------------------------------------
  initial begin
    stepped_address_clock = 1'b0;
    stepped_address_serial_line = 1'b0;
    mirror_reset_serial_line = 1'b1;
  end

  task automatic shift_words(input logic [SHIFT_W-1:0] sa, input logic [SHIFT_W-1:0] mr);
    #3;
    for (int i = SHIFT_W - 1; i >= 0; i--) begin
      stepped_address_serial_line = sa[i];
      mirror_reset_serial_line = mr[i];
      #40 stepped_address_clock = 1'b1;
      // Lines flip while high, so a falling-edge sampler reads garbage
      #20 stepped_address_serial_line = ~sa[i];
      mirror_reset_serial_line = ~mr[i];
      #20 stepped_address_clock = 1'b0;
    end
  endtask
endmodule // mmaip_ctrl_model
`default_nettype wire

// ### test/micromirror_array_input_port_tb.sv
/*
  Self-checking bench for the micromirror array input port.
  Assumes the package, the design and the controller model compile first.
*/
`timescale 1ns/10ps
`default_nettype none
module micromirror_array_input_port_tb
  import mmaip_pkg::*;
();
  logic clock, rst, reset_latch_strobe, reset_driver_output_enable_n;
  logic pixel_ready, overflow_clear;
  int   error_cnt, cmp_count;
  wire logic parallel_ddr_clock, row_latch_load, serial_sync_control, toggle_rate_control;
  wire logic stepped_address_clock, stepped_address_serial_line, mirror_reset_serial_line;
  wire logic [DATA_W-1:0] pixel_data_in, pixel_data_rise, pixel_data_fall;
  wire logic pixel_valid, pixel_overflow, reset_drivers_enable;
  wire logic row_latch_load_rise, row_latch_load_fall, serial_sync_rise, serial_sync_fall;
  wire logic toggle_rate_rise, toggle_rate_fall;
  wire logic [SHIFT_W-1:0] stepped_address_word, mirror_reset_word, reset_driver_out;
  logic [WORD_W-1:0] got;

  mmaip_ctrl_model model (.parallel_ddr_clock, .pixel_data_in, .row_latch_load,
    .serial_sync_control, .toggle_rate_control, .stepped_address_clock,
    .stepped_address_serial_line, .mirror_reset_serial_line);

  mmaip_input_port DUT (.clock, .rst, .parallel_ddr_clock, .pixel_data_in, .row_latch_load,
    .serial_sync_control, .toggle_rate_control, .stepped_address_clock,
    .stepped_address_serial_line, .mirror_reset_serial_line, .reset_latch_strobe,
    .reset_driver_output_enable_n, .pixel_ready, .overflow_clear, .pixel_valid,
    .pixel_data_rise, .pixel_data_fall, .row_latch_load_rise, .row_latch_load_fall,
    .serial_sync_rise, .serial_sync_fall, .toggle_rate_rise, .toggle_rate_fall,
    .pixel_overflow, .stepped_address_word, .mirror_reset_word, .reset_drivers_enable,
    .reset_driver_out);

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // Compare helpers and closing report
  // ----------------------------------------------------------------
  task automatic chk_word(input string nm, input logic [WORD_W-1:0] e, input logic [WORD_W-1:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_ser(input string nm, input logic [SHIFT_W-1:0] e, input logic [SHIFT_W-1:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_flag(input string nm, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic results();
    $display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask

  // ----------------------------------------------------------------
  // Stream monitor: idle zero pairs are skipped
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    got = {toggle_rate_rise, serial_sync_rise, row_latch_load_rise, pixel_data_rise,
           toggle_rate_fall, serial_sync_fall, row_latch_load_fall, pixel_data_fall};
    if (!rst && pixel_valid === 1'b1 && pixel_ready === 1'b1 && got !== '0) begin
      if (model.exp_q.size() == 0) begin
        chk_word("unexpected_pixel_word", '0, got);
      end else begin
        chk_word("pixel_word", model.exp_q.pop_front(), got);
      end
    end
  end

  // Stall every gap-th cycle (never when gap is 0) until the stream drains
  task automatic drain(input int gap);
    int i;
    for (i = 0; i < 3000; i++) begin
      @(negedge clock);
      pixel_ready = (gap == 0) || (i % gap != gap - 1);
      if (model.exp_q.size() == 0 && model.pend == 0) break;
    end
    pixel_ready = 1'b1;
    if (i == 3000) begin
      error_cnt++;
      $display("ERROR drain expected 0 seen %0d", model.exp_q.size());
      results();
    end
  endtask

  task automatic strobe();
    cyc(4);
    reset_latch_strobe = 1'b1;
    cyc(4);
    reset_latch_strobe = 1'b0;
    cyc(5);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset();
    chk_ser("sa_word_reset", 16'h0000, stepped_address_word);
    chk_ser("mr_word_reset", 16'h0000, mirror_reset_word);
    chk_flag("drv_en_reset", 1'b0, reset_drivers_enable);
    chk_flag("overflow_reset", 1'b0, pixel_overflow);
    $display("test_reset done");
  endtask

  task automatic test_stream();
    model.send(24);
    drain(3);
    model.send(9);
    drain(0);
    chk_flag("overflow_stream", 1'b0, pixel_overflow);
    $display("test_stream done");
  endtask

  task automatic test_overflow();
    int i;
    logic seen;
    pixel_ready = 1'b0;
    for (i = 0; i < 400 && pixel_overflow !== 1'b1; i++) cyc(1);
    chk_flag("overflow_set", 1'b1, pixel_overflow);
    if (pixel_overflow !== 1'b1) results();
    // Clear held across several drops: the flag must still show in at least one cycle
    overflow_clear = 1'b1;
    seen = 1'b0;
    repeat (12) begin
      cyc(1);
      seen = seen | pixel_overflow;
    end
    overflow_clear = 1'b0;
    chk_flag("overflow_set_wins", 1'b1, seen);
    pixel_ready = 1'b1;
    cyc(40);
    overflow_clear = 1'b1;
    cyc(2);
    overflow_clear = 1'b0;
    cyc(6);
    chk_flag("overflow_cleared", 1'b0, pixel_overflow);
    model.send(6);
    drain(0);
    $display("test_overflow done");
  endtask

  task automatic test_serial();
    model.shift_words(16'ha5c3, 16'h3c96);
    strobe();
    chk_ser("sa_word", 16'ha5c3, stepped_address_word);
    chk_ser("mr_word", 16'h3c96, mirror_reset_word);
    model.shift_words(16'h1234, 16'hfedc);
    cyc(6);
    chk_ser("sa_word_hold", 16'ha5c3, stepped_address_word);
    chk_ser("mr_word_hold", 16'h3c96, mirror_reset_word);
    strobe();
    chk_ser("sa_word_2", 16'h1234, stepped_address_word);
    chk_ser("mr_word_2", 16'hfedc, mirror_reset_word);
    chk_ser("drv_out_off", 16'h0000, reset_driver_out);
    $display("test_serial done");
  endtask

  task automatic test_driver();
    reset_driver_output_enable_n = 1'b0;
    cyc(4);
    chk_flag("drv_en_on", 1'b1, reset_drivers_enable);
    chk_ser("drv_out_on", 16'hfedc, reset_driver_out);
    reset_driver_output_enable_n = 1'b1;
    cyc(4);
    chk_flag("drv_en_off", 1'b0, reset_drivers_enable);
    chk_ser("drv_out_off2", 16'h0000, reset_driver_out);
    $display("test_driver done");
  endtask

  initial begin
    error_cnt = 0;
    cmp_count = 0;
    rst = 1'b1;
    reset_latch_strobe = 1'b0;
    reset_driver_output_enable_n = 1'b1;
    pixel_ready = 1'b0;
    overflow_clear = 1'b0;
    cyc(12);
    rst = 1'b0;
    pixel_ready = 1'b1;
    model.shift_words(16'h0000, 16'h0000);
    cyc(3);
    test_reset();
    test_stream();
    test_overflow();
    test_serial();
    test_driver();
    results();
  end
endmodule // micromirror_array_input_port_tb
`default_nettype wire
